// file: logic/isspi_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module isspi_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   output logic [WIDTH-1:0]      out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             push, pop;

   assign in_ready_out  = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid_out = cnt_reg != '0;
   assign out_data_out  = mem_reg[rd_reg];

   always_comb begin
      push     = in_valid_in && in_ready_out;
      pop      = out_valid_out && out_ready_in;
      wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_next = (AW+1)'(cnt_reg + push - pop);
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
      if (push) begin
         mem_reg[wr_reg] <= in_data_in;
      end
   end
endmodule : isspi_fifo
`default_nettype wire

// file: logic/isspi_if.sv
// Interface joining the serial master and the sensor serial slave.
`timescale 1ns/1ps
`default_nettype none
interface isspi_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   wire  miso;
   // A released line rests at its pull-up level, so the host never samples an unknown.
   assign miso = miso_oe ? miso_o : 1'b1;
   modport master (output sclk, output cs_n, output mosi, input miso);
   modport slave  (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
endinterface : isspi_if
`default_nettype wire

// file: logic/isspi_master.sv
// Host end: serial master that makes the link clock by division and paces frames.
`timescale 1ns/1ps
`default_nettype none
module isspi_master
   import isspi_pkg::*;
#(
   parameter int WORD_BITS      = ISSPI_WORD_BITS,
   parameter int FIFO_DEPTH     = ISSPI_FIFO_DEPTH,
   parameter int FAST_PERIOD    = ISSPI_FAST_PERIOD_CYC,
   parameter int NORM_PERIOD    = ISSPI_NORM_PERIOD_CYC
) (
   input  wire logic                 clk_in,
   input  wire logic                 srst_in,
   isspi_if.master                   link,
   input  wire logic [7:0]           sample_period_setting_in,
   input  wire logic [WORD_BITS-1:0] cmd_data_in,
   input  wire logic                 cmd_valid_in,
   output logic                      cmd_ready_out,
   output logic [WORD_BITS-1:0]      rsp_data_out,
   output logic                      rsp_valid_out,
   input  wire logic                 rsp_ready_in
);
   localparam int BW = $clog2(WORD_BITS + 1);
   typedef enum logic [1:0] {
      ISSPI_IDLE = 2'b00,
      ISSPI_LOW  = 2'b01,
      ISSPI_HIGH = 2'b10,
      ISSPI_GAP  = 2'b11
   } isspi_state_t;

   logic [WORD_BITS-1:0] f_data;
   logic                 f_valid, f_ready;
   isspi_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in       (clk_in),
      .srst_in      (srst_in),
      .in_data_in   (cmd_data_in),
      .in_valid_in  (cmd_valid_in),
      .in_ready_out (cmd_ready_out),
      .out_data_out (f_data),
      .out_valid_out(f_valid),
      .out_ready_in (f_ready)
   );

   isspi_state_t         st_reg, st_next;
   logic [ISSPI_CNT_W-1:0] div_reg, div_next, per_reg, per_next;
   logic [BW-1:0]        bit_reg, bit_next;
   logic [WORD_BITS-1:0] tx_reg, tx_next, rx_reg, rx_next, rsp_reg, rsp_next;
   logic                 sclk_reg, sclk_next, cs_reg, cs_next, mosi_reg, mosi_next;
   logic                 rv_reg, rv_next, miso_s1_reg, miso_s2_reg, fast;
   logic [ISSPI_CNT_W-1:0] half_c, per_c;

   // -----------------------------------------------------------------
   // Frame sequencer
   // -----------------------------------------------------------------
   always_comb begin
      fast    = sample_period_setting_in <= ISSPI_FAST_MAX_SET;
      half_c  = fast ? ISSPI_CNT_W'(ISSPI_FAST_HALF_CYC) : ISSPI_CNT_W'(ISSPI_NORM_HALF_CYC);
      per_c   = fast ? ISSPI_CNT_W'(FAST_PERIOD) : ISSPI_CNT_W'(NORM_PERIOD);
      st_next = st_reg;
      div_next = div_reg == '0 ? '0 : ISSPI_CNT_W'(div_reg - 1'b1);
      per_next = per_reg == '0 ? '0 : ISSPI_CNT_W'(per_reg - 1'b1);
      bit_next = bit_reg;
      tx_next = tx_reg;
      rx_next = rx_reg;
      rsp_next = rsp_reg;
      sclk_next = sclk_reg;
      cs_next = cs_reg;
      mosi_next = mosi_reg;
      rv_next = rv_reg && !rsp_ready_in;
      f_ready = 1'b0;
      unique case (st_reg)
         ISSPI_IDLE: begin
            // A pending answer stalls the next frame so no word is lost.
            if (f_valid && per_reg == '0 && !rv_reg) begin
               f_ready  = 1'b1;
               tx_next  = {f_data[WORD_BITS-2:0], 1'b0};
               mosi_next = f_data[WORD_BITS-1];
               cs_next  = 1'b0;
               per_next = per_c;
               div_next = half_c;
               bit_next = '0;
               st_next  = ISSPI_HIGH;
            end
         end
         ISSPI_HIGH: if (div_reg == '0) begin
            sclk_next = 1'b0;
            if (bit_reg != '0) begin
               mosi_next = tx_reg[WORD_BITS-1];
               tx_next   = {tx_reg[WORD_BITS-2:0], 1'b0};
            end
            div_next = half_c;
            st_next  = ISSPI_LOW;
         end
         ISSPI_LOW: if (div_reg == '0) begin
            sclk_next = 1'b1;
            rx_next   = {rx_reg[WORD_BITS-2:0], miso_s2_reg};
            bit_next  = BW'(bit_reg + 1'b1);
            div_next  = half_c;
            st_next   = (bit_reg == BW'(WORD_BITS - 1)) ? ISSPI_GAP : ISSPI_HIGH;
         end
         ISSPI_GAP: if (div_reg == '0) begin
            cs_next  = 1'b1;
            rsp_next = rx_reg;
            rv_next  = 1'b1;
            st_next  = ISSPI_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      miso_s1_reg <= link.miso;
      miso_s2_reg <= miso_s1_reg;
      if (srst_in) begin
         st_reg <= ISSPI_IDLE;
         div_reg <= '0;
         per_reg <= '0;
         bit_reg <= '0;
         tx_reg <= '0;
         rx_reg <= '0;
         rsp_reg <= '0;
         sclk_reg <= 1'b1;
         cs_reg <= 1'b1;
         mosi_reg <= 1'b0;
         rv_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         div_reg <= div_next;
         per_reg <= per_next;
         bit_reg <= bit_next;
         tx_reg <= tx_next;
         rx_reg <= rx_next;
         rsp_reg <= rsp_next;
         sclk_reg <= sclk_next;
         cs_reg <= cs_next;
         mosi_reg <= mosi_next;
         rv_reg <= rv_next;
      end
   end

   assign link.sclk     = sclk_reg;
   assign link.cs_n     = cs_reg;
   assign link.mosi     = mosi_reg;
   assign rsp_data_out  = rsp_reg;
   assign rsp_valid_out = rv_reg;
endmodule : isspi_master
`default_nettype wire

// file: logic/isspi_pkg.sv
// Package of constants shared by both ends of the inertial sensor serial port.
//
// Behaviour
// - Clock idles high, sample on second edge.
// - MSB driven as soon as select falls.
// - Next bits shift out after falling clock.
// - Output released when select rises.
// - Input captured on rising clock edge.
// - Fast mode clock within 0.01 to 2.5 MHz.
// - Normal mode clock at most 1.0 MHz.
// - Fast mode select period at least 40 us.
// - Normal mode select period at least 100 us.
package isspi_pkg;
   // -----------------------------------------------------------------
   // Word and timing constants
   // -----------------------------------------------------------------
   localparam int          ISSPI_WORD_BITS      = 16;
   localparam int          ISSPI_FIFO_DEPTH     = 16;
   localparam int          ISSPI_CLK_MHZ        = 200;
   localparam logic [7:0]  ISSPI_FAST_MAX_SET   = 8'h07;
   localparam int          ISSPI_FAST_SCLK_KHZ  = 2500;
   localparam int          ISSPI_NORM_SCLK_KHZ  = 1000;
   localparam int          ISSPI_FAST_PERIOD_US = 40;
   localparam int          ISSPI_NORM_PERIOD_US = 100;
   // Half period of the generated serial clock, rounded up so the rate stays under the limit.
   localparam int ISSPI_FAST_HALF_CYC =
      (ISSPI_CLK_MHZ * 1000 + 2 * ISSPI_FAST_SCLK_KHZ - 1) / (2 * ISSPI_FAST_SCLK_KHZ);
   localparam int ISSPI_NORM_HALF_CYC =
      (ISSPI_CLK_MHZ * 1000 + 2 * ISSPI_NORM_SCLK_KHZ - 1) / (2 * ISSPI_NORM_SCLK_KHZ);
   localparam int ISSPI_FAST_PERIOD_CYC = ISSPI_FAST_PERIOD_US * ISSPI_CLK_MHZ;
   localparam int ISSPI_NORM_PERIOD_CYC = ISSPI_NORM_PERIOD_US * ISSPI_CLK_MHZ;
   localparam int ISSPI_CNT_W           = 16;
endpackage : isspi_pkg

// file: logic/isspi_slave.sv
// Sensor end: serial slave clocked by the link clock, words crossing by handshake.
`timescale 1ns/1ps
`default_nettype none
module isspi_slave
   import isspi_pkg::*;
#(
   parameter int WORD_BITS = ISSPI_WORD_BITS
) (
   input  wire logic                 clk_in,
   input  wire logic                 srst_in,
   isspi_if.slave                    link,
   input  wire logic [WORD_BITS-1:0] tx_data_in,
   input  wire logic                 tx_valid_in,
   output logic                      tx_ready_out,
   output logic [WORD_BITS-1:0]      rx_data_out,
   output logic                      rx_valid_out,
   input  wire logic                 rx_ready_in
);
   localparam int BW = $clog2(WORD_BITS + 1);

   // -----------------------------------------------------------------
   // Transmit word held in the system domain, read across as stable data
   // -----------------------------------------------------------------
   // Loads are refused while a frame runs, so the link side may read the word directly.
   // Select is seen two cycles late, so a load in that window changes the word of this frame.
   logic [WORD_BITS-1:0] txw_reg, txw_next;
   logic                 cs_s1_reg, cs_s2_reg, cs_s3_reg;
   logic                 tx_ready_reg, tx_ready_next;

   always_comb begin
      txw_next      = txw_reg;
      tx_ready_next = tx_ready_reg;
      if (cs_s2_reg && !cs_s3_reg) begin
         tx_ready_next = 1'b1;
      end
      if (!cs_s2_reg && cs_s3_reg) begin
         tx_ready_next = 1'b0;
      end
      if (tx_valid_in && tx_ready_reg) begin
         txw_next      = tx_data_in;
         tx_ready_next = 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Link domain: shift logic on the serial clock
   // -----------------------------------------------------------------
   logic [WORD_BITS-1:0] rsh_reg, rsh_next, rword_reg, rword_next;
   logic [BW-1:0]        rcnt_reg, rcnt_next;
   logic                 rdone_reg, rdone_next;
   logic [WORD_BITS-1:0] osh_reg, osh_next;
   logic                 ostart_reg, ostart_next;

   // Capture on rising clock; chip select high acts as the frame reset.
   always_comb begin
      rsh_next   = {rsh_reg[WORD_BITS-2:0], link.mosi};
      rcnt_next  = BW'(rcnt_reg + 1'b1);
      rword_next = rword_reg;
      rdone_next = rdone_reg;
      // A cut frame clears the flag at its first bit, so no stale word is reported.
      if (rcnt_reg == '0) begin
         rdone_next = 1'b0;
      end
      if (rcnt_reg == BW'(WORD_BITS - 1)) begin
         rcnt_next  = '0;
         rword_next = rsh_next;
         rdone_next = 1'b1;
      end
   end

   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         rsh_reg  <= '0;
         rcnt_reg <= '0;
      end else begin
         rsh_reg  <= rsh_next;
         rcnt_reg <= rcnt_next;
      end
   end

   always_ff @(posedge link.sclk) begin
      rword_reg <= rword_next;
      rdone_reg <= rdone_next;
   end

   // Output shifts on falling clock; the first falling edge keeps the MSB for the first rise.
   always_comb begin
      ostart_next = 1'b1;
      osh_next    = ostart_reg ? {osh_reg[WORD_BITS-2:0], 1'b0} : txw_reg;
   end

   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         ostart_reg <= 1'b0;
         osh_reg    <= '0;
      end else begin
         ostart_reg <= ostart_next;
         osh_reg    <= osh_next;
      end
   end

   // MSB goes out straight from select falling, then the shifter takes over.
   assign link.miso_o  = ostart_reg ? osh_reg[WORD_BITS-1] : txw_reg[WORD_BITS-1];
   assign link.miso_oe = ~link.cs_n;

   // -----------------------------------------------------------------
   // Crossings into the system domain
   // -----------------------------------------------------------------
   logic [WORD_BITS-1:0] rx_data_reg, rx_data_next;
   logic rx_valid_reg, rx_valid_next;

   always_comb begin
      rx_data_next  = rx_data_reg;
      rx_valid_next = rx_valid_reg;
      if (rx_ready_in) begin
         rx_valid_next = 1'b0;
      end
      // The link clock idles while select is high, so the word stands until the next frame.
      if (cs_s2_reg && !cs_s3_reg && rdone_reg) begin
         rx_data_next  = rword_reg;
         rx_valid_next = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      cs_s1_reg <= link.cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      if (srst_in) begin
         txw_reg       <= '0;
         tx_ready_reg  <= 1'b1;
         rx_data_reg   <= '0;
         rx_valid_reg  <= 1'b0;
      end else begin
         txw_reg       <= txw_next;
         tx_ready_reg  <= tx_ready_next;
         rx_data_reg   <= rx_data_next;
         rx_valid_reg  <= rx_valid_next;
      end
   end

   assign tx_ready_out = tx_ready_reg;
   assign rx_data_out  = rx_data_reg;
   assign rx_valid_out = rx_valid_reg;
endmodule : isspi_slave
`default_nettype wire

// file: tb/inertial_sensor_spi_slave_port_tb.sv
// Testbench joining the host end and the sensor end over the serial link.
`timescale 1ns/1ps
`default_nettype none
module inertial_sensor_spi_slave_port_tb;
   // ----------
   // Setup
   // ----------
   localparam int FP = 2000;
   localparam int NP = 5000;
   logic        clk = 1'b0, sclk_s = 1'b0, srst = 1'b1;
   logic [7:0]  setting = 8'h07;
   logic [15:0] cmd_data = 16'h0000, tx_data = 16'h0000, rsp_data, rx_data;
   logic        cmd_valid = 1'b0, rsp_ready = 1'b1, tx_valid = 1'b0, rx_ready = 1'b1;
   logic        cmd_ready, rsp_valid, tx_ready, rx_valid;
   logic [15:0] rspq[$], rxq[$];
   int          num_errors = 0, checks_done = 0;
   always #2.5 clk = ~clk;
   // An unrelated sensor-side clock makes the word crossing do real work.
   always #3.1 sclk_s = ~sclk_s;
   isspi_if lnk ();
   isspi_master #(.FAST_PERIOD(FP), .NORM_PERIOD(NP)) isspi_master_inst (.clk_in(clk),
      .srst_in(srst), .link(lnk), .sample_period_setting_in(setting), .cmd_data_in(cmd_data),
      .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .rsp_data_out(rsp_data),
      .rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready));
   isspi_slave isspi_slave_inst (.clk_in(sclk_s), .srst_in(srst), .link(lnk),
      .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
      .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready));
   isspi_link_properties #(.FAST_PERIOD(FP), .NORM_PERIOD(NP)) isspi_link_properties_inst (
      .clk_in(clk), .srst_in(srst), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
      .miso_oe(lnk.miso_oe), .miso(lnk.miso), .sample_period_setting_in(setting));
   always @(posedge clk) if (rsp_valid === 1'b1 && rsp_ready === 1'b1) rspq.push_back(rsp_data);
   always @(posedge sclk_s) if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
   // ----------
   // Tasks
   // ----------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic push_cmd(input logic [15:0] w, output bit ok);
      int n;
      n = 0;
      ok = 1'b0;
      #1 cmd_data = w;
      cmd_valid = 1'b1;
      while (!ok && n < 40) begin
         @(posedge clk);
         ok = (cmd_ready === 1'b1);
         n++;
      end
   endtask : push_cmd
   task automatic load_tx(input logic [15:0] w);
      int n;
      n = 0;
      @(posedge sclk_s);
      #1 tx_data = w;
      tx_valid = 1'b1;
      do begin
         @(posedge sclk_s);
         n++;
      end while (tx_ready !== 1'b1 && n < 4000);
      #1 tx_valid = 1'b0;
      check({15'h0000, n < 4000}, 16'h0001);
      @(posedge clk);
   endtask : load_tx
   task automatic wait_frames(input int n);
      int i;
      for (i = 0; i < 60000 && (rspq.size() < n || rxq.size() < n); i++) @(posedge clk);
      check({15'h0000, i < 60000}, 16'h0001);
   endtask : wait_frames
   task automatic expect_word(input logic [15:0] rsp_exp, input logic [15:0] rx_exp);
      check(rspq.size() > 0 ? rspq.pop_front() : 16'hxxxx, rsp_exp);
      check(rxq.size() > 0 ? rxq.pop_front() : 16'hxxxx, rx_exp);
   endtask : expect_word
   task automatic run_fast();
      bit ok;
      load_tx(16'ha53c);
      push_cmd(16'h3c5a, ok);
      #1 cmd_valid = 1'b0;
      wait_frames(1);
      expect_word(16'ha53c, 16'h3c5a);
   endtask : run_fast
   task automatic run_normal();
      bit ok;
      #1 setting = 8'h08;
      repeat (NP) @(posedge clk);
      load_tx(16'h8001);
      push_cmd(16'hffff, ok);
      push_cmd(16'h0001, ok);
      #1 cmd_valid = 1'b0;
      wait_frames(2);
      expect_word(16'h8001, 16'hffff);
      expect_word(16'h8001, 16'h0001);
   endtask : run_normal
   task automatic run_fill();
      bit ok;
      int acc;
      acc = 0;
      ok = 1'b1;
      #1 setting = 8'h07;
      rsp_ready = 1'b0;
      repeat (NP) @(posedge clk);
      load_tx(16'h0f0f);
      while (ok && acc < 20) begin
         push_cmd(16'h1000 + 16'(acc), ok);
         acc += ok;
      end
      #1 cmd_valid = 1'b0;
      check({15'h0000, acc >= 16 && acc <= 17}, 16'h0001);
      repeat (3000) @(posedge clk);
      check({15'h0000, rsp_valid}, 16'h0001);
      check(16'(rspq.size()), 16'h0000);
      #1 rsp_ready = 1'b1;
      wait_frames(acc);
      for (int i = 0; i < acc; i++) expect_word(16'h0f0f, 16'h1000 + 16'(i));
   endtask : run_fill
   task automatic conclude();
      if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   initial begin
      repeat (16) @(posedge clk);
      #1 srst = 1'b0;
      run_fast();
      run_normal();
      run_fill();
      conclude();
   end
   // The run needs about 54000 host cycles; the rest is margin for slow handshakes.
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      conclude();
   end
endmodule : inertial_sensor_spi_slave_port_tb
`default_nettype wire

// file: tb/isspi_link_properties.sv
// Checker of the serial link between the host end and the sensor end.
`timescale 1ns/1ps
`default_nettype none
module isspi_link_properties #(
   parameter int FAST_PERIOD = 8000,
   parameter int NORM_PERIOD = 20000
) (
   input wire logic       clk_in,
   input wire logic       srst_in,
   input wire logic       sclk,
   input wire logic       cs_n,
   input wire logic       mosi,
   input wire logic       miso_oe,
   input wire logic       miso,
   input wire logic [7:0] sample_period_setting_in
);
   // ----------
   // Counters
   // ----------
   logic [15:0] lo_reg, lo_next, hi_reg, hi_next, gap_reg, gap_next;
   logic [7:0]  age_reg, age_next;
   logic [4:0]  rise_reg, rise_next;
   logic        sclk_reg, cs_reg, fast;
   assign fast = (sample_period_setting_in <= 8'h07);
   always_comb begin
      lo_next   = sclk ? 16'h0000 : lo_reg + 16'h0001;
      hi_next   = (sclk && !cs_n) ? hi_reg + 16'h0001 : 16'h0000;
      gap_next  = (cs_reg && !cs_n) ? 16'h0001 : gap_reg + {15'h0000, gap_reg != 16'hffff};
      age_next  = ((sclk_reg && !sclk) || (cs_reg && !cs_n)) ? 8'h00 :
                  age_reg + {7'h00, age_reg != 8'hff};
      rise_next = cs_n ? 5'h00 : rise_reg + {4'h0, sclk && !sclk_reg};
   end
   // Saturating counts keep the first frame after reset from looking too close.
   always_ff @(posedge clk_in) begin
      {lo_reg, hi_reg, gap_reg, age_reg, rise_reg, sclk_reg, cs_reg} <= srst_in ?
         {32'h0000_0000, 16'hffff, 8'hff, 5'h00, 2'h3} :
         {lo_next, hi_next, gap_next, age_next, rise_next, sclk, cs_n};
   end
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);
   a_idle_clock_high: assert property (cs_n |-> sclk)
      else $error("clock low while deselected");
   a_sixteen_clocks: assert property ($rose(cs_n) |-> rise_reg == 5'h10)
      else $error("frame without sixteen clocks");
   a_output_released: assert property (cs_n |-> !miso_oe)
      else $error("output driven while deselected");
   a_msb_on_select: assert property ($fell(cs_n) |-> miso_oe ##1 $stable(miso) [*8])
      else $error("first bit not held from select");
   a_out_after_fall: assert property (!cs_n && $changed(miso) |-> age_next <= 8'h14)
      else $error("output moved away from falling clock");
   a_input_held: assert property ($rose(sclk) |-> mosi == $past(mosi, 5) ##1 $stable(mosi) [*8])
      else $error("input moved near rising clock");
   a_low_phase_rate: assert property ($rose(sclk) |->
      lo_reg >= (fast ? 16'h0028 : 16'h0064) && lo_reg <= 16'h2710)
      else $error("clock low phase out of range");
   a_high_phase_rate: assert property (!cs_n && $fell(sclk) |->
      hi_reg >= (fast ? 16'h0028 : 16'h0064))
      else $error("clock high phase too short");
   a_frame_spacing: assert property ($fell(cs_n) |->
      gap_reg >= (fast ? FAST_PERIOD : NORM_PERIOD))
      else $error("frames too close");
   c_fast_frame: cover property ($fell(cs_n) && fast);
   c_norm_frame: cover property ($fell(cs_n) && !fast);
   c_back_to_back: cover property ($fell(cs_n) && gap_reg <= 16'h1f40);
endmodule : isspi_link_properties
`default_nettype wire
